// >>> logic/angle_filter_map.vh
// register map, field positions and timing constants for the angle post-processing filter
`ifndef ANGLE_FILTER_MAP_VH
`define ANGLE_FILTER_MAP_VH

// register word offsets (byte addresses)
`define REG_CONFIG        4'h0
`define REG_ANGLE         4'h4
`define REG_STATUS        4'h8
`define REG_IRQ_MASK      4'hC

// config_register field positions
`define CFG_PM_LO         0
`define CFG_OUTPUT_HYSTERESIS_SEL_LO       2
`define CFG_OUTPUT_TYPE_SEL_LO       4
`define CFG_SF_LO         8
`define CFG_FTH_LO        10
`define CFG_WD_BIT        13
`define CFG_RESET         32'h0000_0000

// status register bits
`define ST_MAGNET_BIT     0
`define ST_FAST_BIT       1
`define ST_WD_LP_BIT      2
`define IRQ_MAG_LOST      0
`define IRQ_MAG_FOUND     1
`define IRQ_WD_ENTER      2
`define IRQ_WD_LEAVE      3

// output type code for pwm
`define OUTPUT_TYPE_SEL_PWM          2'b10

// filter step-response delays in ns
`define SF_DELAY0_NS      2200000
`define SF_DELAY1_NS      1100000
`define SF_DELAY2_NS      550000
`define SF_DELAY3_NS      286000
`define CLK_PERIOD_NS     8

// watchdog: idle window and band
`define WD_TIME_MS        60000
`define WD_BAND_LSB       12'h004

`endif

// >>> logic/sample_ram.v
// two-entry sample store; entry 0 holds the watchdog reference angle, entry 1 is unused
`timescale 1ns/1ps
module sample_ram (
    // clock
    input  wire        clk,
    // write port
    input  wire        we,
    input  wire        waddr,
    input  wire [11:0] wdata,
    // read port
    input  wire        raddr,
    output reg  [11:0] rdata
);
    reg [11:0] mem [0:1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// >>> logic/angle_postprocess_filter.v
// angle post-processing filter: slow/fast filter, direction, hysteresis, power modes
`timescale 1ns/1ps
// Summary of operation
// - fast filter enabled only when fast threshold field is nonzero
// - with fast filter off, slow linear filter alone sets step response
// - slow field selects delay 2.2, 1.1, 0.55 or 0.286 ms
// - fast filter applies only when input variation exceeds the threshold
// - threshold codes 001..111 give slow-to-fast/fast-to-slow 6/1..10/4 LSB
// - fast filter reaches error band within two sample periods, then slow settles
// - direction 0 increases angle clockwise, 1 counterclockwise
// - output hysteresis of 1 to 3 LSB by hysteresis field
// - weak field drives output low and magnet flag reads zero
// - three low-power modes selected by power mode field, managed automatically
// - watchdog enters deepest mode after angle stays within 4 LSB one minute
// - watchdog active only when its enable bit is set
// - output type analog by default, pwm on code 10 with converter off
`include "angle_filter_map.vh"
module angle_postprocess_filter #(
    // one minute of cycles needs 33 bits at this clock, held in 43
    parameter [42:0] WD_CYCLES = 43'((64'd`WD_TIME_MS * 64'd1000000) / `CLK_PERIOD_NS)
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // angle stream from the front end
    input  wire [11:0] raw_angle,
    input  wire        raw_valid,
    input  wire        field_ok,
    input  wire        dir,
    // output stage
    output reg  [11:0] out_angle_q,
    output reg         out_valid_q,
    output reg         pwm_mode_q,
    output reg         dac_enable_q,
    output reg  [1:0]  power_mode_q,
    output wire        irq,
    // avalon-mm slave
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    output reg  [1:0]  response
);
    localparam [21:0] SF0 = (`SF_DELAY0_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [21:0] SF1 = (`SF_DELAY1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [21:0] SF2 = (`SF_DELAY2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [21:0] SF3 = (`SF_DELAY3_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam ST_IDLE = 1'b0;
    localparam ST_ACK  = 1'b1;

    reg [31:0] cfg_q;
    reg [3:0]  sts_q;
    reg [3:0]  mask_q;
    reg        bus_q;
    reg [31:0] filt_q;
    reg        fast_q;
    reg [1:0]  fast_cnt_q;
    reg [11:0] output_hysteresis_sel_ref_q;
    reg [42:0] wd_cnt_q;
    reg        wd_lp_q;
    reg        mag_q;
    reg [11:0] wd_ref;

    wire [1:0] pm_sel   = cfg_q[`CFG_PM_LO+1:`CFG_PM_LO];
    wire [1:0] output_hysteresis_sel_sel = cfg_q[`CFG_OUTPUT_HYSTERESIS_SEL_LO+1:`CFG_OUTPUT_HYSTERESIS_SEL_LO];
    wire [1:0] output_type_sel_sel = cfg_q[`CFG_OUTPUT_TYPE_SEL_LO+1:`CFG_OUTPUT_TYPE_SEL_LO];
    wire [1:0] sf_sel   = cfg_q[`CFG_SF_LO+1:`CFG_SF_LO];
    wire [2:0] fth_sel  = cfg_q[`CFG_FTH_LO+2:`CFG_FTH_LO];
    wire       wd_en    = cfg_q[`CFG_WD_BIT];

    // circular distance between two 12-bit angles
    function [11:0] adist;
        input [11:0] a;
        input [11:0] b;
        reg   [11:0] d;
        begin
            d = a - b;
            adist = d[11] ? (12'h000 - d) : d;
        end
    endfunction

    function [4:0] fth_up;
        input [2:0] s;
        begin
            case (s)
                3'd1:    fth_up = 5'd6;
                3'd2:    fth_up = 5'd7;
                3'd3:    fth_up = 5'd9;
                3'd4:    fth_up = 5'd18;
                3'd5:    fth_up = 5'd21;
                3'd6:    fth_up = 5'd24;
                3'd7:    fth_up = 5'd10;
                default: fth_up = 5'd0;
            endcase
        end
    endfunction

    function [2:0] fth_dn;
        input [2:0] s;
        begin
            fth_dn = (s == 3'd7) ? 3'd4 : ((s >= 3'd4) ? 3'd2 : 3'd1);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // direction and filter
    wire [11:0] dir_angle = dir ? (12'h000 - raw_angle) : raw_angle;
    wire [11:0] filt_ang  = filt_q[31:20];
    wire [11:0] diff      = adist(dir_angle, filt_ang);
    wire        fast_on   = (fth_sel != 3'd0);

    // slow filter: one-pole, coefficient 1/2^k picks the delay per sample
    reg [21:0] sf_cycles;
    reg [3:0]  sf_shift;
    always @* begin
        case (sf_sel)
            2'b00:   begin sf_cycles = SF0; sf_shift = 4'd5; end
            2'b01:   begin sf_cycles = SF1; sf_shift = 4'd4; end
            2'b10:   begin sf_cycles = SF2; sf_shift = 4'd3; end
            default: begin sf_cycles = SF3; sf_shift = 4'd2; end
        endcase
    end

    wire [31:0] in_ext  = {dir_angle, 20'h0_0000};
    wire [31:0] delta   = in_ext - filt_q;
    reg  [31:0] slow_step;
    always @* begin
        slow_step = $signed(delta) >>> sf_shift;
    end

    ////////////////////////////////////////////////////////////////////////////
    // hysteresis and watchdog
    wire [11:0] output_hysteresis_sel_band = {10'h000, output_hysteresis_sel_sel};
    wire        output_hysteresis_sel_move = adist(filt_ang, output_hysteresis_sel_ref_q) > output_hysteresis_sel_band;
    wire        wd_move   = adist(dir_angle, wd_ref) > `WD_BAND_LSB;
    wire        ev_mag_lost  = mag_q & ~field_ok;
    wire        ev_mag_found = ~mag_q & field_ok;
    wire        ev_wd_enter  = wd_en & ~wd_lp_q & raw_valid & ~wd_move
                               & (wd_cnt_q >= WD_CYCLES - 43'd1);
    // clearing the enable drops low power at once, not at the next sample
    wire        ev_wd_leave  = wd_lp_q & ((raw_valid & wd_move) | ~wd_en);

    // watchdog reference lives in the small store
    reg  [11:0] ref_unused;
    wire        ref_we = raw_valid & (wd_move | ~wd_en);
    wire [11:0] ram_q;
    sample_ram u_ram (
        .clk   (clk),
        .we    (ref_we),
        .waddr (1'b0),
        .wdata (dir_angle),
        .raddr (1'b0),
        .rdata (ram_q)
    );
    always @* begin
        wd_ref     = ram_q;
        ref_unused = 12'h000;
    end

    always @(posedge clk) begin
        if (rst) begin
            filt_q       <= 32'h0000_0000;
            fast_q       <= 1'b0;
            fast_cnt_q   <= 2'd0;
            output_hysteresis_sel_ref_q   <= 12'h000;
            out_angle_q  <= 12'h000;
            out_valid_q  <= 1'b0;
            wd_cnt_q     <= 43'd0;
            wd_lp_q      <= 1'b0;
            mag_q        <= 1'b0;
            pwm_mode_q   <= 1'b0;
            dac_enable_q <= 1'b1;
            power_mode_q <= 2'd0;
        end else begin
            mag_q       <= field_ok;
            out_valid_q <= raw_valid;
            if (raw_valid) begin
                if (fast_on && (fast_q || diff > {7'h00, fth_up(fth_sel)})) begin
                    // fast path lands on the input within two samples
                    filt_q     <= fast_cnt_q == 2'd1 ? in_ext
                                  : filt_q + ($signed(delta) >>> 1);
                    fast_q     <= 1'b1;
                    fast_cnt_q <= (fast_cnt_q == 2'd2) ? 2'd2 : fast_cnt_q + 2'd1;
                    if (fast_cnt_q != 2'd0 && diff <= {9'h000, fth_dn(fth_sel)}) begin
                        fast_q     <= 1'b0;
                        fast_cnt_q <= 2'd0;
                    end
                end else begin
                    filt_q     <= filt_q + slow_step;
                    fast_q     <= 1'b0;
                    fast_cnt_q <= 2'd0;
                end
                if (output_hysteresis_sel_move) begin
                    output_hysteresis_sel_ref_q <= filt_ang;
                end
                if (ref_we || ev_wd_leave) begin
                    wd_cnt_q <= 43'd0;
                end else if (wd_en && !wd_lp_q) begin
                    wd_cnt_q <= wd_cnt_q + 43'd1;
                end
            end else if (wd_en && !wd_lp_q && wd_cnt_q < WD_CYCLES) begin
                wd_cnt_q <= wd_cnt_q + 43'd1;
            end
            if (ev_wd_enter) begin
                wd_lp_q <= 1'b1;
            end else if (ev_wd_leave) begin
                wd_lp_q <= 1'b0;
            end
            out_angle_q  <= field_ok ? output_hysteresis_sel_ref_q : 12'h000;
            pwm_mode_q   <= (output_type_sel_sel == `OUTPUT_TYPE_SEL_PWM);
            dac_enable_q <= (output_type_sel_sel != `OUTPUT_TYPE_SEL_PWM);
            power_mode_q <= wd_lp_q ? 2'd3 : pm_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // avalon-mm slave, answers one cycle after the request
    wire        req   = (read | write) & ~bus_q;
    wire        rd_st = read & ~bus_q & (address == `REG_STATUS);
    wire [3:0]  ev    = {ev_wd_leave, ev_wd_enter, ev_mag_found, ev_mag_lost};
    reg  [31:0] wmask;
    assign waitrequest = (read | write) & ~bus_q;
    assign irq = |(sts_q & mask_q);

    always @* begin
        wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                 {8{byteenable[1]}}, {8{byteenable[0]}}};
    end

    always @(posedge clk) begin
        if (rst) begin
            cfg_q    <= `CFG_RESET;
            sts_q    <= 4'h0;
            mask_q   <= 4'h0;
            bus_q    <= ST_IDLE;
            readdata <= 32'h0000_0000;
            response <= 2'b00;
        end else begin
            bus_q    <= req ? ST_ACK : ST_IDLE;
            // a read clears status, but an event in that cycle still lands
            sts_q    <= (rd_st ? 4'h0 : sts_q) | ev;
            response <= 2'b00;
            if (req && read) begin
                case (address)
                    `REG_CONFIG:   readdata <= cfg_q;
                    `REG_ANGLE:    readdata <= {20'h0_0000, out_angle_q};
                    `REG_STATUS:   readdata <= {25'h000_0000, sts_q, wd_lp_q, fast_q,
                                               field_ok};
                    `REG_IRQ_MASK: readdata <= {28'h000_0000, mask_q};
                    default: begin
                        readdata <= 32'h0000_0000;
                        response <= 2'b10;
                    end
                endcase
            end
            if (req && write) begin
                case (address)
                    `REG_CONFIG:   cfg_q  <= (cfg_q & ~wmask) | (writedata & wmask & 32'h0000_3F3F);
                    `REG_IRQ_MASK: if (byteenable[0]) mask_q <= writedata[3:0];
                    default:       response <= 2'b10;
                endcase
            end
        end
    end
endmodule

// >>> testbench/front_end_model.sv
// front end model: paced angle samples and field flag
`timescale 1ns/1ps
module front_end_model #(
    parameter GAP = 8
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // set by the bench
    input  wire [11:0] angle_set,
    input  wire        field_set,
    // to the filter
    output reg  [11:0] raw_angle,
    output reg         raw_valid,
    output reg         field_ok
);
    reg [7:0] cnt_q;
    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= 8'h00;
            raw_valid <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == GAP - 1) ? 8'h00 : cnt_q + 8'h01;
            raw_valid <= (cnt_q == 8'h00);
        end
        // outside a sample the bus shows garbage, not the last angle
        raw_angle <= (cnt_q == 8'h00) ? angle_set : ~angle_set;
        field_ok <= field_set;
    end
endmodule

// >>> testbench/angle_postprocess_filter_checker.sv
// checker: port assertions for the angle filter
`timescale 1ns/1ps
`include "angle_filter_map.vh"
module angle_postprocess_filter_checker (
    // clock and reset
    input wire        clk,
    input wire        rst,
    // stream
    input wire        raw_valid,
    input wire        field_ok,
    input wire [11:0] out_angle_q,
    input wire        out_valid_q,
    input wire        pwm_mode_q,
    input wire        dac_enable_q,
    input wire [1:0]  power_mode_q,
    // bus
    input wire [3:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire        waitrequest
);
    reg [13:0] cfg_q;
    always @(posedge clk) begin
        if (rst)
            cfg_q <= 14'h0000;
        else if (write && !waitrequest && address == `REG_CONFIG)
            cfg_q <= writedata[13:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_OUT_TYPE: assert property (pwm_mode_q != dac_enable_q)
        else $error("pwm and converter enable agree");
    AST_PWM_SEL: assert property ($stable(cfg_q)[*3] |-> pwm_mode_q == (cfg_q[5:4] == 2'b10))
        else $error("pwm mode differs from config");
    AST_NO_FIELD: assert property (!field_ok |=> out_angle_q == 12'h000)
        else $error("angle not low without field");
    AST_WD_OFF: assert property (($stable(cfg_q) && !cfg_q[13])[*3] |-> power_mode_q == cfg_q[1:0])
        else $error("power mode moved with watchdog off");
    AST_PM_SET: assert property ($stable(cfg_q)[*2] |-> power_mode_q inside {cfg_q[1:0], 2'b11})
        else $error("power mode not from config");
    AST_LP_CAUSE: assert property ($rose(power_mode_q == 2'b11) && cfg_q[1:0] != 2'b11 |-> cfg_q[13])
        else $error("deepest mode without watchdog");
    AST_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus wait longer than one cycle");
    AST_VALID_LAG: assert property (raw_valid |=> out_valid_q)
        else $error("sample valid not passed on");
endmodule

// >>> testbench/angle_postprocess_filter_tb_top.sv
// testbench: bus tasks and filter scenarios
`timescale 1ns/1ps
`include "angle_filter_map.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module angle_postprocess_filter_tb_top;
    reg         clk, rst, field_set, dir, read, write;
    reg  [11:0] angle_set;
    reg  [3:0]  address;
    reg  [31:0] writedata, rdat;
    reg  [1:0]  resp;
    wire [11:0] raw_angle, out_angle_q;
    wire [31:0] readdata;
    wire [1:0]  power_mode_q, response;
    wire        raw_valid, field_ok, out_valid_q, pwm_mode_q, dac_enable_q, irq, waitrequest;
    int         error_cnt = 0, total_checks = 0, k;
    front_end_model front_end_model_i (.clk(clk), .rst(rst), .angle_set(angle_set),
        .field_set(field_set), .raw_angle(raw_angle), .raw_valid(raw_valid), .field_ok(field_ok));
    angle_postprocess_filter #(.WD_CYCLES(43'd200)) angle_postprocess_filter_i (.clk(clk),
        .rst(rst), .raw_angle(raw_angle), .raw_valid(raw_valid), .field_ok(field_ok), .dir(dir),
        .out_angle_q(out_angle_q), .out_valid_q(out_valid_q), .pwm_mode_q(pwm_mode_q),
        .dac_enable_q(dac_enable_q), .power_mode_q(power_mode_q), .irq(irq), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
        .readdata(readdata), .waitrequest(waitrequest), .response(response));
    ////////////////////////////////////////////////////////////////////////////////
    task conclude;
        begin
            if (error_cnt == 0 && total_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // request held until waitrequest is sampled low at a rising edge, released there
    task bus(input w, input [3:0] a, input [31:0] d);
        begin
            @(posedge clk);
            address <= a;
            writedata <= d;
            read <= !w;
            write <= w;
            @(posedge clk);
            while (waitrequest !== 1'b0) @(posedge clk);
            rdat = readdata;
            resp = response;
            read <= 1'b0;
            write <= 1'b0;
        end
    endtask
    task stim(input [11:0] a, input f, input d);
        begin
            @(posedge clk);
            angle_set <= a;
            field_set <= f;
            dir <= d;
        end
    endtask
    task cyc(input int n);
        begin
            repeat (n) @(posedge clk);
            @(negedge clk);
        end
    endtask
    // truncation in the filter leaves a few lsb of slack
    function near(input [11:0] e);
        reg [11:0] t;
        begin
            t = out_angle_q - e + 12'h003;
            near = (t <= 12'h006);
        end
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude;
    end
    initial begin
        rst = 1'b1; read = 1'b0; write = 1'b0; address = 4'h0; writedata = 32'h0000_0000;
        angle_set = 12'h000; field_set = 1'b1; dir = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        `CHK("dac_enable_q", 1'b1, dac_enable_q)
        `CHK("power_mode_q", 2'b00, power_mode_q)
        bus(0, `REG_CONFIG, 0);
        `CHK("config", 32'h0000_0000, rdat)
        bus(0, 4'h2, 0);
        `CHK("response", 2'b10, resp)
        bus(1, `REG_CONFIG, 32'h0000_0400);
        stim(12'h064, 1, 0); cyc(40);
        `CHK("fast settle", 1'b1, near(12'h064))
        stim(12'h258, 1, 0); cyc(34);
        `CHK("fast step", 1'b1, near(12'h258))
        bus(1, `REG_CONFIG, 32'h0000_0000);
        stim(12'h3e8, 1, 0); cyc(34);
        `CHK("slow step", 1'b1, out_angle_q < 12'h384)
        for (k = 1; k < 8; k++) begin
            bus(1, `REG_CONFIG, k << 10);
            stim(12'(1000 + k * 40), 1, 0); cyc(40);
            `CHK("fth code", 1'b1, near(12'(1000 + k * 40)))
        end
        bus(1, `REG_CONFIG, 32'h0000_1800);
        stim(12'h50c, 1, 0); cyc(40);
        `CHK("below thr", 1'b0, near(12'h50c))
        bus(1, `REG_CONFIG, 32'h0000_1f00);
        stim(12'h064, 1, 0); cyc(40);
        `CHK("dir cw", 1'b1, near(12'h064))
        stim(12'h064, 1, 1); cyc(40);
        `CHK("dir ccw", 1'b1, near(12'hf9c))
        stim(12'h064, 1, 0);
        bus(1, `REG_IRQ_MASK, 32'h0000_0001);
        stim(12'h064, 0, 0); cyc(2);
        `CHK("no field out", 12'h000, out_angle_q)
        `CHK("irq lost", 1'b1, irq)
        bus(0, `REG_STATUS, 0);
        `CHK("status", 2'b10, {rdat[3], rdat[0]})
        cyc(1);
        `CHK("irq clear", 1'b0, irq)
        bus(1, `REG_IRQ_MASK, 32'h0000_0000);
        stim(12'h064, 1, 0); cyc(4);
        `CHK("irq masked", 1'b0, irq)
        bus(1, `REG_IRQ_MASK, 32'h0000_0002); cyc(1);
        `CHK("irq found", 1'b1, irq)
        bus(0, `REG_STATUS, 0); cyc(1);
        `CHK("found clear", 2'b10, {rdat[4], irq})
        bus(1, `REG_CONFIG, 32'h0000_0020); cyc(2);
        `CHK("pwm", 2'b10, {pwm_mode_q, dac_enable_q})
        bus(1, `REG_CONFIG, 32'h0000_2301); cyc(400);
        `CHK("wd enter", 2'b11, power_mode_q)
        stim(12'h0a0, 1, 0); cyc(30);
        `CHK("wd leave", 2'b01, power_mode_q)
        bus(1, `REG_CONFIG, 32'h0000_0301); cyc(400);
        `CHK("wd off", 2'b01, power_mode_q)
        bus(0, `REG_ANGLE, 0);
        `CHK("angle reg", out_angle_q, rdat[11:0])
        bus(1, `REG_CONFIG, 32'h0000_030d);
        stim(12'h0a2, 1, 0); cyc(60);
        `CHK("output_hysteresis_sel hold", rdat[11:0], out_angle_q)
        conclude;
    end
endmodule
bind angle_postprocess_filter angle_postprocess_filter_checker angle_postprocess_filter_checker_i (
    .clk(clk), .rst(rst), .raw_valid(raw_valid), .field_ok(field_ok),
    .out_angle_q(out_angle_q), .out_valid_q(out_valid_q), .pwm_mode_q(pwm_mode_q),
    .dac_enable_q(dac_enable_q), .power_mode_q(power_mode_q), .address(address),
    .read(read), .write(write), .writedata(writedata), .waitrequest(waitrequest));
